// ==== mcu_add_and_bit_ops.sv ====
// Notes on behaviour
// - add with carry puts work plus immediate plus carry in work, sets z, half carry and carry, one cycle.
// - plain add puts work plus immediate in work without the carry, sets z, half carry and carry, one cycle.
// - register and combines work with data register 0 to 63 and touches only z, one cycle.
// - for register and, select 0 writes work and select 1 writes the data register.
// - immediate and puts work and immediate in work, touching only z, one cycle.
// - bit clear zeroes the chosen bit of the data register, nothing else changes, one cycle.
// - bit set forces the chosen bit of the data register to one, nothing else changes, one cycle.
// - carry is one on a carry out of bit 7 during addition, zero when an addition has none, and holds its value on other ops.
`timescale 1ns/1ps
`default_nettype none
module mcu_add_and_bit_ops
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic op_valid,
    input wire maab_pkg::maab_op_e op,
    input wire logic [7:0] imm,
    input wire logic [5:0] reg_addr,
    input wire logic [2:0] bit_sel,
    input wire logic dest_sel,
    output logic [5:0] rf_raddr,
    input wire logic [7:0] rf_rdata,
    output logic rf_we,
    output logic [5:0] rf_waddr,
    output logic [7:0] rf_wdata,
    output logic [7:0] working_register,
    output logic zero_flag,
    output logic half_carry_flag,
    output logic carry_flag
);
    maab_alu_if alu_bus();
    logic [7:0] work_q;
    logic [7:0] work_d;
    logic work_we;
    logic z_q;
    logic z_d;
    logic dc_q;
    logic c_q;
    logic arith_we;
    logic z_we;
    logic [7:0] and_res;
    logic [7:0] bit_mask;
    logic rf_we_q;
    logic [5:0] rf_waddr_q;
    logic [7:0] rf_wdata_q;

    // one-hot mask for the selected bit position
    function automatic logic [7:0] bit_onehot(input logic [2:0] pos);
        bit_onehot = 8'h01 << pos;
    endfunction

    maab_adder u_adder
    (
        .bus(alu_bus)
    );

    // operands steer into the shared adder
    assign alu_bus.a = work_q;
    assign alu_bus.b = imm;
    assign alu_bus.cin = (op == maab_pkg::OP_ADD_IMM_WITH_CARRY) ? c_q
        : 1'b0;
    assign rf_raddr = reg_addr;
    assign and_res = work_q & ((op == maab_pkg::OP_AND_IMM) ? imm
        : rf_rdata);
    assign bit_mask = bit_onehot(bit_sel);

    // decode: which state the current operation touches
    always_comb
    begin
        work_d = work_q;
        work_we = 1'b0;
        arith_we = 1'b0;
        z_we = 1'b0;
        if (op_valid)
        begin
            unique case (op)
                maab_pkg::OP_ADD_IMM_WITH_CARRY,
                maab_pkg::OP_ADD_IMM:
                begin
                    work_d = alu_bus.sum;
                    work_we = 1'b1;
                    arith_we = 1'b1;
                    z_we = 1'b1;
                end
                maab_pkg::OP_AND_WORK_WITH_REG:
                begin
                    work_d = and_res;
                    work_we = !dest_sel;
                    z_we = 1'b1;
                end
                maab_pkg::OP_AND_IMM:
                begin
                    work_d = and_res;
                    work_we = 1'b1;
                    z_we = 1'b1;
                end
                default:
                begin
                    work_d = work_q; // bit ops leave work and flags alone
                end
            endcase
        end
    end
    assign z_d = (work_d == 8'h00) ? 1'b1 : 1'b0;

    // working register; every op retires in a single edge
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            work_q <= maab_pkg::WORK_RST;
        else if (work_we)
            work_q <= work_d;
    end

    // zero flag, also on and results sent to the data register
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            z_q <= maab_pkg::FLAG_RST;
        else if (z_we)
            z_q <= (and_res == 8'h00 && !arith_we) ? 1'b1
                : (arith_we ? z_d : 1'b0);
    end

    // carry and half carry change only on additions
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            c_q <= maab_pkg::FLAG_RST;
            dc_q <= maab_pkg::FLAG_RST;
        end
        else if (arith_we)
        begin
            c_q <= alu_bus.carry;
            dc_q <= alu_bus.half_carry;
        end
    end

    // data register write-back, registered so data outputs come from flops
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            rf_we_q <= 1'b0;
            rf_waddr_q <= 6'h00;
            rf_wdata_q <= 8'h00;
        end
        else
        begin
            rf_we_q <= 1'b0;
            rf_waddr_q <= reg_addr;
            if (op_valid && op == maab_pkg::OP_AND_WORK_WITH_REG && dest_sel)
            begin
                rf_we_q <= 1'b1;
                rf_wdata_q <= and_res;
            end
            else if (op_valid && op == maab_pkg::OP_BIT_CLEAR)
            begin
                rf_we_q <= 1'b1;
                rf_wdata_q <= rf_rdata & ~bit_mask;
            end
            else if (op_valid && op == maab_pkg::OP_BIT_SET)
            begin
                rf_we_q <= 1'b1;
                rf_wdata_q <= rf_rdata | bit_mask;
            end
        end
    end

    assign rf_we = rf_we_q;
    assign rf_waddr = rf_waddr_q;
    assign rf_wdata = rf_wdata_q;
    assign working_register = work_q;
    assign zero_flag = z_q;
    assign half_carry_flag = dc_q;
    assign carry_flag = c_q;

    sequence s_add_issued;
        op_valid && (op == maab_pkg::OP_ADD_IMM);
    endsequence

    a_add_result_work: assert property (@(posedge clk) disable iff (!rstn)
        s_add_issued |=> work_q == 8'($past(work_q) + $past(imm)))
        else $error("plain add result wrong");
    a_adc_uses_carry: assert property (@(posedge clk) disable iff (!rstn)
        op_valid && op == maab_pkg::OP_ADD_IMM_WITH_CARRY |=>
        work_q == 8'($past(work_q) + $past(imm) + {7'h00, $past(c_q)}))
        else $error("add with carry result wrong");
    a_carry_out_bit7: assert property (@(posedge clk) disable iff (!rstn)
        s_add_issued |=>
        c_q == (({1'b0, $past(work_q)} + {1'b0, $past(imm)}) > 9'h0ff))
        else $error("carry flag wrong");
    a_half_carry_nib: assert property (@(posedge clk) disable iff (!rstn)
        s_add_issued |=> dc_q ==
        (({1'b0, $past(work_q[3:0])} + {1'b0, $past(imm[3:0])}) > 5'h0f))
        else $error("half carry wrong");
    a_and_imm_work: assert property (@(posedge clk) disable iff (!rstn)
        op_valid && op == maab_pkg::OP_AND_IMM |=>
        work_q == ($past(work_q) & $past(imm)) && $stable(c_q)
        && z_q == (work_q == 8'h00))
        else $error("immediate and wrong");
    a_and_reg_dest: assert property (@(posedge clk) disable iff (!rstn)
        op_valid && op == maab_pkg::OP_AND_WORK_WITH_REG && dest_sel |=>
        rf_we && rf_wdata == ($past(work_q) & $past(rf_rdata))
        && $stable(work_q))
        else $error("register and to data register wrong");
    a_and_reg_flags: assert property (@(posedge clk) disable iff (!rstn)
        op_valid && op == maab_pkg::OP_AND_WORK_WITH_REG |=>
        $stable(c_q) && $stable(dc_q)
        && z_q == (($past(work_q) & $past(rf_rdata)) == 8'h00))
        else $error("register and flags wrong");
    a_bit_clear_data: assert property (@(posedge clk) disable iff (!rstn)
        op_valid && op == maab_pkg::OP_BIT_CLEAR |=> rf_we
        && rf_wdata == ($past(rf_rdata) & ~(8'h01 << $past(bit_sel)))
        && $stable(z_q) && $stable(c_q) && $stable(work_q))
        else $error("bit clear wrong");
    a_bit_set_data: assert property (@(posedge clk) disable iff (!rstn)
        op_valid && op == maab_pkg::OP_BIT_SET |=> rf_we
        && rf_wdata == ($past(rf_rdata) | (8'h01 << $past(bit_sel)))
        && $stable(z_q) && $stable(dc_q) && $stable(work_q))
        else $error("bit set wrong");
endmodule
`default_nettype wire

// ==== maab_pkg.sv ====
package maab_pkg;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 6;
    localparam int BIT_W = 3;
    localparam int HALF_BIT = 4;
    localparam logic [7:0] WORK_RST = 8'h00;
    localparam logic FLAG_RST = 1'b0;
    localparam int CYCLES_PER_OP = 1;
    // opcodes presented by the decoder
    typedef enum logic [2:0]
    {
        OP_NONE,
        OP_ADD_IMM_WITH_CARRY,
        OP_ADD_IMM,
        OP_AND_WORK_WITH_REG,
        OP_AND_IMM,
        OP_BIT_CLEAR,
        OP_BIT_SET
    } maab_op_e;
endpackage

// ==== maab_alu_if.sv ====
`timescale 1ns/1ps
`default_nettype none
// operands to and results from the combinational arithmetic unit
interface maab_alu_if;
    logic [7:0] a;
    logic [7:0] b;
    logic cin;
    logic [7:0] sum;
    logic half_carry;
    logic carry;
    modport core (output a, output b, output cin,
        input sum, input half_carry, input carry);
    modport alu (input a, input b, input cin,
        output sum, output half_carry, output carry);
endinterface
`default_nettype wire

// ==== maab_adder.sv ====
`timescale 1ns/1ps
`default_nettype none
module maab_adder
(
    maab_alu_if.alu bus
);
    logic [4:0] low;
    logic [4:0] high;
    // split at the nibble so the half carry falls out for free
    always_comb
    begin
        low = {1'b0, bus.a[3:0]} + {1'b0, bus.b[3:0]} + {4'h0, bus.cin};
        high = {1'b0, bus.a[7:4]} + {1'b0, bus.b[7:4]} + {4'h0, low[4]};
    end
    assign bus.sum = {high[3:0], low[3:0]};
    assign bus.half_carry = low[4];
    assign bus.carry = high[4];
endmodule
`default_nettype wire

// ==== tb_mcu_add_and_bit_ops.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_mcu_add_and_bit_ops;
    typedef struct packed
    {
        logic [7:0] w;
        logic z;
        logic h;
        logic c;
        logic we;
        logic [5:0] wa;
        logic [7:0] wd;
    } maab_exp_s;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic op_valid = 1'b0;
    maab_pkg::maab_op_e op = maab_pkg::OP_NONE;
    logic [7:0] imm = 8'h00;
    logic [5:0] reg_addr = 6'h00;
    logic [2:0] bit_sel = 3'h0;
    logic dest_sel = 1'b0;
    logic [7:0] rf_rdata = 8'h00;
    logic [5:0] rf_raddr;
    logic [5:0] rf_waddr;
    logic [7:0] rf_wdata;
    logic [7:0] working_register;
    logic rf_we;
    logic zero_flag;
    logic half_carry_flag;
    logic carry_flag;
    maab_exp_s exp_q[$];
    maab_exp_s m;
    maab_exp_s e_n;
    logic taken = 1'b0;
    int err_count = 0;
    int n_compared = 0;
    int cycles = 0;
    integer seed = 8952;
    logic [10:0] got_st;
    logic [14:0] got_wr;

    // write port is only meaningful while the strobe is up
    assign got_st = {working_register, zero_flag, half_carry_flag, carry_flag};
    assign got_wr = {rf_we, rf_we ? {rf_waddr, rf_wdata} : 14'h0000};

    initial
    begin
        forever #25 clk = ~clk;
    end

    mcu_add_and_bit_ops dut_u
    (
        .clk(clk),
        .rstn(rstn),
        .op_valid(op_valid),
        .op(op),
        .imm(imm),
        .reg_addr(reg_addr),
        .bit_sel(bit_sel),
        .dest_sel(dest_sel),
        .rf_raddr(rf_raddr),
        .rf_rdata(rf_rdata),
        .rf_we(rf_we),
        .rf_waddr(rf_waddr),
        .rf_wdata(rf_wdata),
        .working_register(working_register),
        .zero_flag(zero_flag),
        .half_carry_flag(half_carry_flag),
        .carry_flag(carry_flag)
    );

    task automatic test_done();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic check_state(input maab_exp_s e);
        n_compared++;
        if (got_st !== {e.w, e.z, e.h, e.c})
        begin
            err_count++;
            $display("mismatch state exp %h got %h", {e.w, e.z, e.h, e.c}, got_st);
        end
    endtask

    task automatic check_write(input maab_exp_s e);
        n_compared++;
        if (got_wr !== {e.we, e.wa, e.wd})
        begin
            err_count++;
            $display("mismatch write exp %h got %h", {e.we, e.wa, e.wd}, got_wr);
        end
    endtask

    // drive one op and note its expected outcome from the reference model
    task automatic issue(input maab_pkg::maab_op_e o, input logic [7:0] i,
        input logic [5:0] a, input logic [2:0] b, input logic d,
        input logic [7:0] r);
        logic [8:0] s;
        logic cin;
        @(posedge clk);
        op_valid <= 1'b1;
        op <= o;
        imm <= i;
        reg_addr <= a;
        bit_sel <= b;
        dest_sel <= d;
        rf_rdata <= r;
        m.we = 1'b0;
        m.wa = 6'h00;
        m.wd = 8'h00;
        cin = (o == maab_pkg::OP_ADD_IMM_WITH_CARRY) && m.c;
        case (o)
            maab_pkg::OP_ADD_IMM_WITH_CARRY, maab_pkg::OP_ADD_IMM:
            begin
                s = m.w + i + cin;
                m.h = ({1'b0, m.w[3:0]} + i[3:0] + cin) > 5'h0f;
                m.c = s[8];
                m.w = s[7:0];
                m.z = s[7:0] == 8'h00;
            end
            maab_pkg::OP_AND_WORK_WITH_REG:
            begin
                m.z = (m.w & r) == 8'h00;
                m.we = d;
                m.wa = d ? a : 6'h00;
                m.wd = d ? (m.w & r) : 8'h00;
                m.w = d ? m.w : (m.w & r);
            end
            maab_pkg::OP_AND_IMM:
            begin
                m.w = m.w & i;
                m.z = m.w == 8'h00;
            end
            maab_pkg::OP_BIT_CLEAR, maab_pkg::OP_BIT_SET:
            begin
                m.we = 1'b1;
                m.wa = a;
                m.wd = r;
                m.wd[b] = (o == maab_pkg::OP_BIT_SET);
            end
            default:
            begin
            end
        endcase
        exp_q.push_back(m);
    endtask

    // results show one cycle after the op is taken
    always @(posedge clk)
    begin
        taken <= op_valid;
        cycles <= cycles + 1;
        if (cycles == 2000)
        begin
            err_count++;
            test_done();
        end
    end

    always @(negedge clk)
    begin
        if (taken && exp_q.size() > 0)
        begin
            e_n = exp_q.pop_front();
            check_state(e_n);
            check_write(e_n);
        end
    end

    initial
    begin
        m = '0;
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        // carry, half-carry and zero boundaries, then the and and bit ops, back to back
        issue(maab_pkg::OP_ADD_IMM, 8'h12, 6'h00, 3'h0, 1'b0, 8'h00);
        issue(maab_pkg::OP_ADD_IMM, 8'h34, 6'h00, 3'h0, 1'b0, 8'h00);
        issue(maab_pkg::OP_ADD_IMM, 8'hba, 6'h00, 3'h0, 1'b0, 8'h00);
        issue(maab_pkg::OP_ADD_IMM_WITH_CARRY, 8'h0f, 6'h00, 3'h0, 1'b0, 8'h00);
        issue(maab_pkg::OP_ADD_IMM, 8'hf0, 6'h00, 3'h0, 1'b0, 8'h00);
        issue(maab_pkg::OP_ADD_IMM_WITH_CARRY, 8'hff, 6'h00, 3'h0, 1'b0, 8'h00);
        issue(maab_pkg::OP_ADD_IMM, 8'h5a, 6'h00, 3'h0, 1'b0, 8'h00);
        issue(maab_pkg::OP_AND_WORK_WITH_REG, 8'h00, 6'h3f, 3'h0, 1'b1, 8'haf);
        issue(maab_pkg::OP_AND_WORK_WITH_REG, 8'h00, 6'h01, 3'h0, 1'b0, 8'ha5);
        issue(maab_pkg::OP_BIT_CLEAR, 8'h00, 6'h05, 3'h3, 1'b1, 8'h5a);
        issue(maab_pkg::OP_BIT_SET, 8'h00, 6'h05, 3'h7, 1'b0, 8'h5a);
        issue(maab_pkg::OP_AND_IMM, 8'h00, 6'h00, 3'h0, 1'b0, 8'h00);
        $display("test directed done");
        // random ops with idle gaps; idle ops must leave state untouched
        repeat (300)
        begin
            if ($random(seed) % 4 == 0)
            begin
                @(posedge clk);
                op_valid <= 1'b0;
                op <= maab_pkg::maab_op_e'({$random(seed)} % 7);
            end
            else
                issue(maab_pkg::maab_op_e'({$random(seed)} % 7),
                    8'($random(seed)), 6'($random(seed)), 3'($random(seed)),
                    1'($random(seed)), 8'($random(seed)));
        end
        @(posedge clk);
        op_valid <= 1'b0;
        repeat (3) @(posedge clk);
        $display("test random done");
        test_done();
    end
endmodule
`default_nettype wire
